// *** logic/dlct_timers.sv ***
// Dual counter/timer with shared prescaler and auxiliary clock selection
// ==========================================================================
// Summary of operation
// - Prescale codes give sysclk /12, /4, /48
// - Code three uses synchronised external clock /8
// - Timer B sysclk select, ignored when counting
// - Timer A sysclk select, ignored when counting
// - Aux low-byte select: sysclk or own source
// - Aux high-byte select applies in split mode
// - Counter mode counts falling pin edges
// - Runs only with run and open gate, except B and A high in split mode
// - Setting run keeps the count untouched
// - Mode 0 is thirteen-bit high/low-five count
// - Thirteen-bit rollover sets the overflow flag
// - Mode 1 is the full sixteen-bit count
// - Mode 2 reloads low from high
// - Split mode: A low is own timer
// - Split mode: A high uses B run, flag
// - Split mode: B no external clock, flag
// - Split mode: B runs unless mode three
// - Timer B gate uses pin B polarity
// - Each timer has its own settings
// - Mode codes, code three split or idle
// - Flag clears on vector ack or write
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ns
`include "dlct_defines.svh"
module dlct_timers (
    // Clock and reset
    input logic sys_clk,
    input logic reset_n,
    // Register port
    input logic [7:0] reg_addr,
    input logic [7:0] reg_wdata,
    input logic reg_wr,
    input logic reg_rd,
    output logic [7:0] reg_rdata,
    // External pins
    input logic timer_a_count_pin,
    input logic timer_b_count_pin,
    input logic ext_irq_pin_a,
    input logic ext_irq_pin_b,
    input logic ext_clock_pin,
    // Interrupt controller side
    input logic timer_a_irq_enable,
    input logic timer_b_irq_enable,
    input logic timer_a_irq_ack,
    input logic timer_b_irq_ack,
    output logic timer_a_irq_req,
    output logic timer_b_irq_req,
    // Consumers of timer B overflow
    output logic timer_b_overflow_pulse,
    // Auxiliary timer time bases
    output logic aux_timer_a_low_tick,
    output logic aux_timer_a_high_tick,
    output logic aux_timer_b_low_tick,
    output logic aux_timer_b_high_tick
);
    dlct_pkg::dlct_core_s state_ff;
    dlct_pkg::dlct_core_s nxt_state;
    logic [`DLCT_SYNC_W-1:0] pin_lvl;
    logic [`DLCT_SYNC_W-1:0] pin_fall;
    logic presc_tick;
    logic div12_tick;
    logic ext8_tick;
    dlct_pkg::dlct_mode_e mode_a;
    dlct_pkg::dlct_mode_e mode_b;
    logic a_split;
    logic gate_open_a;
    logic gate_open_b;
    logic run_a;
    logic run_b;
    logic tick_a;
    logic tick_b;
    logic tick_ah;
    logic [16:0] adv_a;
    logic [16:0] adv_b;
    logic [8:0] adv_ah;
    logic ovf_a;
    logic ovf_b;
    logic ovf_ah;
    logic set_tf_a;
    logic set_tf_b;
    logic wr_ctrl;

    // ======================================================================
    // Pin synchronisers and prescaler
    // Bits: 0 count A, 1 count B, 2 irq A, 3 irq B, 4 external clock
    dlct_sync u_sync (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .pin_in({ext_clock_pin, ext_irq_pin_b, ext_irq_pin_a,
                 timer_b_count_pin, timer_a_count_pin}),
        .level(pin_lvl),
        .fall(pin_fall)
    );

    dlct_presc u_presc (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .code(state_ff.clksel[1:0]),
        .ext_edge(pin_fall[4]),
        .presc_tick(presc_tick),
        .div12_tick(div12_tick),
        .ext8_tick(ext8_tick)
    );

    // ======================================================================
    // Count advance for one timer: returns {overflow, high, low}
    function automatic logic [16:0] advance(input logic [1:0] md,
                                            input logic [7:0] lo,
                                            input logic [7:0] hi);
        logic [13:0] v13;
        logic [16:0] v16;
        logic [8:0] v8;
        v13 = {1'b0, hi, lo[4:0]} + 14'h0001;
        v16 = {1'b0, hi, lo} + 17'h00001;
        v8 = {1'b0, lo} + 9'h001;
        unique case (md)
            2'h0: advance = {v13[13], v13[12:5], lo[7:5], v13[4:0]};
            2'h1: advance = v16;
            2'h2: advance = {v8[8], hi, v8[8] ? hi : v8[7:0]};
            default: advance = {v8[8], hi, v8[7:0]};
        endcase
    endfunction

    // ======================================================================
    // Clocking and gating
    always_comb begin
        mode_a = dlct_pkg::dlct_mode_e'(state_ff.mode[1:0]);
        mode_b = dlct_pkg::dlct_mode_e'(state_ff.mode[5:4]);
        a_split = mode_a == dlct_pkg::DLCT_MSPLIT;
        // Gate pins are active at the level set by their polarity bit
        gate_open_a = !state_ff.mode[`DLCT_MODE_GATE_A] ||
                      (pin_lvl[2] == state_ff.irqcfg[`DLCT_IRQCFG_POL_A]);
        gate_open_b = !state_ff.mode[`DLCT_MODE_GATE_B] ||
                      (pin_lvl[3] == state_ff.irqcfg[`DLCT_IRQCFG_POL_B]);
        run_a = state_ff.ctrl[`DLCT_CTRL_RUN_A] && gate_open_a;
        if (a_split) begin
            run_b = mode_b != dlct_pkg::DLCT_MSPLIT;
        end else begin
            run_b = state_ff.ctrl[`DLCT_CTRL_RUN_B] && gate_open_b &&
                    (mode_b != dlct_pkg::DLCT_MSPLIT);
        end
        if (state_ff.mode[`DLCT_MODE_CT_A]) begin
            tick_a = pin_fall[0];
        end else begin
            tick_a = state_ff.clksel[`DLCT_CLK_SYS_A] | presc_tick;
        end
        // Timer B loses its external clock while A is split
        if (state_ff.mode[`DLCT_MODE_CT_B] && !a_split) begin
            tick_b = pin_fall[1];
        end else begin
            tick_b = state_ff.clksel[`DLCT_CLK_SYS_B] | presc_tick;
        end
        tick_ah = state_ff.clksel[`DLCT_CLK_SYS_A] | presc_tick;
    end

    // ======================================================================
    // Next state
    always_comb begin
        nxt_state = state_ff;
        adv_a = advance(state_ff.mode[1:0], state_ff.a_low, state_ff.a_high);
        adv_b = advance(state_ff.mode[5:4], state_ff.b_low, state_ff.b_high);
        adv_ah = {1'b0, state_ff.a_high} + 9'h001;
        ovf_a = run_a && tick_a && adv_a[16];
        ovf_b = run_b && tick_b && adv_b[16];
        ovf_ah = a_split && state_ff.ctrl[`DLCT_CTRL_RUN_B] && tick_ah && adv_ah[8];
        set_tf_a = ovf_a;
        set_tf_b = a_split ? ovf_ah : ovf_b;
        wr_ctrl = reg_wr && (reg_addr == `DLCT_OFS_CTRL);
        // One increment per tick; count bytes change only on clock edges
        if (run_a && tick_a) begin
            nxt_state.a_low = adv_a[7:0];
            nxt_state.a_high = adv_a[15:8];
        end
        if (a_split && state_ff.ctrl[`DLCT_CTRL_RUN_B] && tick_ah) begin
            nxt_state.a_high = adv_ah[7:0];
        end
        if (run_b && tick_b) begin
            nxt_state.b_low = adv_b[7:0];
            nxt_state.b_high = adv_b[15:8];
        end
        nxt_state.b_ovf = ovf_b;
        // A software write to a count byte wins over counting in that cycle
        if (reg_wr) begin
            unique case (reg_addr)
                `DLCT_OFS_CTRL: nxt_state.ctrl = reg_wdata;
                `DLCT_OFS_MODE: nxt_state.mode = reg_wdata;
                `DLCT_OFS_A_LOW: nxt_state.a_low = reg_wdata;
                `DLCT_OFS_B_LOW: nxt_state.b_low = reg_wdata;
                `DLCT_OFS_A_HIGH: nxt_state.a_high = reg_wdata;
                `DLCT_OFS_B_HIGH: nxt_state.b_high = reg_wdata;
                `DLCT_OFS_CLKSEL: nxt_state.clksel = reg_wdata;
                `DLCT_OFS_IRQCFG: nxt_state.irqcfg = reg_wdata[1:0];
                `DLCT_OFS_AUXCTL: nxt_state.auxctl = reg_wdata[3:0];
                default: ;
            endcase
        end
        // Hardware set wins over a vector ack or software clear
        nxt_state.ctrl[`DLCT_CTRL_TF_A] = set_tf_a ||
            (nxt_state.ctrl[`DLCT_CTRL_TF_A] && !timer_a_irq_ack);
        nxt_state.ctrl[`DLCT_CTRL_TF_B] = set_tf_b ||
            (nxt_state.ctrl[`DLCT_CTRL_TF_B] && !timer_b_irq_ack);
        // Read data stand for one cycle only; unmapped reads give zero
        nxt_state.rdata = `DLCT_RST_BYTE;
        if (reg_rd) begin
            unique case (reg_addr)
                `DLCT_OFS_CTRL: nxt_state.rdata = state_ff.ctrl;
                `DLCT_OFS_MODE: nxt_state.rdata = state_ff.mode;
                `DLCT_OFS_A_LOW: nxt_state.rdata = state_ff.a_low;
                `DLCT_OFS_B_LOW: nxt_state.rdata = state_ff.b_low;
                `DLCT_OFS_A_HIGH: nxt_state.rdata = state_ff.a_high;
                `DLCT_OFS_B_HIGH: nxt_state.rdata = state_ff.b_high;
                `DLCT_OFS_CLKSEL: nxt_state.rdata = state_ff.clksel;
                `DLCT_OFS_IRQCFG: nxt_state.rdata = {6'h00, state_ff.irqcfg};
                `DLCT_OFS_AUXCTL: nxt_state.rdata = {4'h0, state_ff.auxctl};
                default: nxt_state.rdata = `DLCT_RST_BYTE;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ======================================================================
    // Outputs
    assign reg_rdata = state_ff.rdata;
    assign timer_a_irq_req = state_ff.ctrl[`DLCT_CTRL_TF_A] && timer_a_irq_enable;
    assign timer_b_irq_req = state_ff.ctrl[`DLCT_CTRL_TF_B] && timer_b_irq_enable;
    assign timer_b_overflow_pulse = state_ff.b_ovf;

    // Auxiliary sources: external choice is the external clock /8, else sysclk /12
    always_comb begin
        aux_timer_a_low_tick = state_ff.clksel[`DLCT_CLK_AUXA_LO] ||
            (state_ff.auxctl[`DLCT_AUX_A_XCLK] ? ext8_tick : div12_tick);
        aux_timer_b_low_tick = state_ff.clksel[`DLCT_CLK_AUXB_LO] ||
            (state_ff.auxctl[`DLCT_AUX_B_XCLK] ? ext8_tick : div12_tick);
        aux_timer_a_high_tick = aux_timer_a_low_tick;
        aux_timer_b_high_tick = aux_timer_b_low_tick;
        if (state_ff.auxctl[`DLCT_AUX_A_SPLIT]) begin
            aux_timer_a_high_tick = state_ff.clksel[`DLCT_CLK_AUXA_HI] ||
                (state_ff.auxctl[`DLCT_AUX_A_XCLK] ? ext8_tick : div12_tick);
        end
        if (state_ff.auxctl[`DLCT_AUX_B_SPLIT]) begin
            aux_timer_b_high_tick = state_ff.clksel[`DLCT_CLK_AUXB_HI] ||
                (state_ff.auxctl[`DLCT_AUX_B_XCLK] ? ext8_tick : div12_tick);
        end
    end

    // ======================================================================
    // Assertions
    logic wr_a_cnt;
    assign wr_a_cnt = reg_wr && (reg_addr == `DLCT_OFS_A_LOW || reg_addr == `DLCT_OFS_A_HIGH);
    logic wr_b_cnt;
    assign wr_b_cnt = reg_wr &&
        (reg_addr == `DLCT_OFS_B_LOW || reg_addr == `DLCT_OFS_B_HIGH);

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    property p_stop_holds;
        (!state_ff.ctrl[`DLCT_CTRL_RUN_A] && !a_split && !wr_a_cnt)
            |=> (state_ff.a_low == $past(state_ff.a_low)) &&
                (state_ff.a_high == $past(state_ff.a_high));
    endproperty
    a_stop_holds: assert property (p_stop_holds) else $error("Timer A moved while stopped");

    property p_run_keeps_count;
        (wr_ctrl && reg_wdata[`DLCT_CTRL_RUN_A] && !state_ff.ctrl[`DLCT_CTRL_RUN_A])
            |=> state_ff.a_low == $past(state_ff.a_low);
    endproperty
    a_run_keeps_count: assert property (p_run_keeps_count) else $error("Run set changed count");

    property p_m13_wrap;
        (mode_a == dlct_pkg::DLCT_M13 && run_a && tick_a && !reg_wr &&
         state_ff.a_high == 8'hFF && state_ff.a_low[4:0] == 5'h1F)
            |=> state_ff.ctrl[`DLCT_CTRL_TF_A] && state_ff.a_high == 8'h00 &&
                state_ff.a_low[4:0] == 5'h00;
    endproperty
    a_m13_wrap: assert property (p_m13_wrap) else $error("Thirteen-bit wrap wrong");

    property p_m16_wrap;
        (mode_a == dlct_pkg::DLCT_M16 && run_a && tick_a && !reg_wr &&
         {state_ff.a_high, state_ff.a_low} == 16'hFFFF)
            |=> state_ff.ctrl[`DLCT_CTRL_TF_A] && {state_ff.a_high, state_ff.a_low} == 16'h0000;
    endproperty
    a_m16_wrap: assert property (p_m16_wrap) else $error("Sixteen-bit wrap wrong");

    property p_reload;
        (mode_a == dlct_pkg::DLCT_M8R && run_a && tick_a && !reg_wr && state_ff.a_low == 8'hFF)
            |=> state_ff.a_low == $past(state_ff.a_high) &&
                state_ff.a_high == $past(state_ff.a_high);
    endproperty
    a_reload: assert property (p_reload) else $error("Auto-reload failed");

    property p_ack_clears;
        (timer_a_irq_ack && !set_tf_a && !wr_ctrl) |=> !state_ff.ctrl[`DLCT_CTRL_TF_A];
    endproperty
    a_ack_clears: assert property (p_ack_clears) else $error("Ack left flag set");

    property p_split_b_quiet;
        (a_split && !ovf_ah && !state_ff.ctrl[`DLCT_CTRL_TF_B] && !wr_ctrl)
            |=> !state_ff.ctrl[`DLCT_CTRL_TF_B];
    endproperty
    a_split_b_quiet: assert property (p_split_b_quiet) else $error("B flag set in split");

    property p_count_edge;
        (state_ff.mode[`DLCT_MODE_CT_A] && !pin_fall[0] && !wr_a_cnt && !a_split)
            |=> state_ff.a_low == $past(state_ff.a_low);
    endproperty
    a_count_edge: assert property (p_count_edge) else $error("Counted without edge");

    property p_presc_gap;
        (presc_tick && state_ff.clksel[1:0] == 2'h1) |=> (!presc_tick)[*3];
    endproperty
    a_presc_gap: assert property (p_presc_gap) else $error("Divide by four spacing");

    property p_hi_run;
        (a_split && !state_ff.ctrl[`DLCT_CTRL_RUN_B] && !wr_a_cnt)
            |=> state_ff.a_high == $past(state_ff.a_high);
    endproperty
    a_hi_run: assert property (p_hi_run) else $error("Split high ran");

    property p_b_idle;
        (mode_b == dlct_pkg::DLCT_MSPLIT && !wr_b_cnt)
            |=> state_ff.b_low == $past(state_ff.b_low) &&
                state_ff.b_high == $past(state_ff.b_high);
    endproperty
    a_b_idle: assert property (p_b_idle) else $error("Timer B ran in mode three");

    property p_b_wrap_pulse;
        (mode_b == dlct_pkg::DLCT_M13 && run_b && tick_b && !wr_b_cnt &&
         state_ff.b_high == 8'hFF && state_ff.b_low[4:0] == 5'h1F)
            |=> timer_b_overflow_pulse && state_ff.b_high == 8'h00;
    endproperty
    a_b_wrap_pulse: assert property (p_b_wrap_pulse) else $error("B wrap no pulse");
endmodule

// *** logic/dlct_defines.svh ***
// Register offsets, field positions, reset values and divide ratios of the counter/timer pair
`ifndef DLCT_DEFINES_SVH
`define DLCT_DEFINES_SVH

// ==========================================================================
// Register offsets
`define DLCT_OFS_CTRL 8'h88
`define DLCT_OFS_MODE 8'h89
`define DLCT_OFS_A_LOW 8'h8A
`define DLCT_OFS_B_LOW 8'h8B
`define DLCT_OFS_A_HIGH 8'h8C
`define DLCT_OFS_B_HIGH 8'h8D
`define DLCT_OFS_CLKSEL 8'h8E
`define DLCT_OFS_IRQCFG 8'h90
`define DLCT_OFS_AUXCTL 8'h91

// ==========================================================================
// Field positions
`define DLCT_CTRL_TF_B 7
`define DLCT_CTRL_RUN_B 6
`define DLCT_CTRL_TF_A 5
`define DLCT_CTRL_RUN_A 4
`define DLCT_MODE_GATE_B 7
`define DLCT_MODE_CT_B 6
`define DLCT_MODE_GATE_A 3
`define DLCT_MODE_CT_A 2
`define DLCT_CLK_AUXB_HI 7
`define DLCT_CLK_AUXB_LO 6
`define DLCT_CLK_AUXA_HI 5
`define DLCT_CLK_AUXA_LO 4
`define DLCT_CLK_SYS_B 3
`define DLCT_CLK_SYS_A 2
`define DLCT_IRQCFG_POL_A 0
`define DLCT_IRQCFG_POL_B 1
`define DLCT_AUX_A_XCLK 0
`define DLCT_AUX_B_XCLK 1
`define DLCT_AUX_A_SPLIT 2
`define DLCT_AUX_B_SPLIT 3

// ==========================================================================
// Reset values and divide ratios
`define DLCT_RST_BYTE 8'h00
`define DLCT_DIV_LONG 6'h30
`define DLCT_DIV_MID 6'h0C
`define DLCT_DIV_SHORT 6'h04
`define DLCT_DIV_EXT 3'h0
`define DLCT_SYNC_W 5

`endif

// *** logic/dlct_pkg.sv ***
// Types shared by the counter/timer pair and its helpers
package dlct_pkg;

    // ======================================================================
    // Timer modes
    typedef enum logic [1:0] {
        DLCT_M13 = 2'h0,
        DLCT_M16 = 2'h1,
        DLCT_M8R = 2'h2,
        DLCT_MSPLIT = 2'h3
    } dlct_mode_e;

    // ======================================================================
    // State records
    typedef struct packed {
        logic [4:0] s1;
        logic [4:0] s2;
        logic [4:0] s3;
        logic [4:0] lvl;
    } dlct_sync_s;

    typedef struct packed {
        logic [5:0] cnt;
        logic [2:0] ext_cnt;
    } dlct_presc_s;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] mode;
        logic [7:0] a_low;
        logic [7:0] a_high;
        logic [7:0] b_low;
        logic [7:0] b_high;
        logic [7:0] clksel;
        logic [1:0] irqcfg;
        logic [3:0] auxctl;
        logic [7:0] rdata;
        logic b_ovf;
    } dlct_core_s;

endpackage

// *** logic/dlct_sync.sv ***
// Three-stage input synchroniser with agreement filter and falling-edge pulse
`timescale 1ns/1ns
`include "dlct_defines.svh"
module dlct_sync (
    // Clock and reset
    input logic sys_clk,
    input logic reset_n,
    // Pins
    input logic [`DLCT_SYNC_W-1:0] pin_in,
    // Filtered view
    output logic [`DLCT_SYNC_W-1:0] level,
    output logic [`DLCT_SYNC_W-1:0] fall
);
    dlct_pkg::dlct_sync_s state_ff;
    dlct_pkg::dlct_sync_s nxt_state;

    // ======================================================================
    // Filter
    always_comb begin
        nxt_state = state_ff;
        nxt_state.s1 = pin_in;
        nxt_state.s2 = state_ff.s1;
        nxt_state.s3 = state_ff.s2;
        // A change is taken only once the second and third stages agree
        nxt_state.lvl = (state_ff.s2 & state_ff.s3) |
                        (state_ff.lvl & (state_ff.s2 | state_ff.s3));
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign level = state_ff.lvl;
    assign fall = state_ff.lvl & ~nxt_state.lvl;
endmodule

// *** logic/dlct_presc.sv ***
// Shared prescaler: sysclk /12, /4, /48 and external clock /8
`timescale 1ns/1ns
`include "dlct_defines.svh"
module dlct_presc (
    // Clock and reset
    input logic sys_clk,
    input logic reset_n,
    // Control
    input logic [1:0] code,
    input logic ext_edge,
    // Ticks
    output logic presc_tick,
    output logic div12_tick,
    output logic ext8_tick
);
    dlct_pkg::dlct_presc_s state_ff;
    dlct_pkg::dlct_presc_s nxt_state;
    logic t4;
    logic t48;

    // ======================================================================
    // Dividers
    always_comb begin
        nxt_state = state_ff;
        nxt_state.cnt = (state_ff.cnt == `DLCT_DIV_LONG - 6'h01) ? 6'h00 : state_ff.cnt + 6'h01;
        if (ext_edge) begin
            nxt_state.ext_cnt = state_ff.ext_cnt + 3'h1;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // One counter serves all three sysclk ratios, so a code change never waits a full long period
    assign t4 = state_ff.cnt[1:0] == 2'(`DLCT_DIV_SHORT - 6'h01);
    assign div12_tick = (state_ff.cnt % `DLCT_DIV_MID) == `DLCT_DIV_MID - 6'h01;
    assign t48 = state_ff.cnt == `DLCT_DIV_LONG - 6'h01;
    assign ext8_tick = ext_edge && (state_ff.ext_cnt == `DLCT_DIV_EXT - 3'h1);

    always_comb begin
        unique case (code)
            2'h0: presc_tick = div12_tick;
            2'h1: presc_tick = t4;
            2'h2: presc_tick = t48;
            default: presc_tick = ext8_tick;
        endcase
    end
endmodule

// *** sim/dlct_pins_model.sv ***
// Model of the count, gate and external clock pins in front of the timer pair
`timescale 1ns/1ns
module dlct_pins_model (
    // Clock
    input wire logic sys_clk,
    // Pins
    output logic count_a,
    output logic count_b,
    output logic ext_clk,
    output logic gate_a,
    output logic gate_b
);
    // Count and clock pins idle high so the first event is a clean falling edge; gate pins idle low
    initial begin
        count_a = 1'b1;
        count_b = 1'b1;
        ext_clk = 1'b1;
        gate_a = 1'b0;
        gate_b = 1'b0;
    end

    task automatic drive(input int sel, input logic v);
        case (sel)
            0: count_a <= v;
            1: count_b <= v;
            2: ext_clk <= v;
            3: gate_a <= v;
            default: gate_b <= v;
        endcase
    endtask

    // Falling edges with each level held hold cycles, at least two; faster pulses may be lost
    task automatic edges(input int sel, input int n, input int hold);
        int h;
        h = (hold < 2) ? 2 : hold;
        @(posedge sys_clk);
        repeat (n) begin
            drive(sel, 1'b0);
            repeat (h) @(posedge sys_clk);
            drive(sel, 1'b1);
            repeat (h) @(posedge sys_clk);
        end
    endtask
endmodule

// *** sim/dlct_timers_bench.sv ***
// Self-checking bench of the counter/timer pair
`timescale 1ns/1ns
module dlct_timers_bench;
    logic sys_clk, reset_n, reg_wr, reg_rd, en_a, en_b, ack_a, ack_b;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, v0, v1, ca, cb, ha, hb, n_ovf;
    logic tk_ah, tk_bh, ovp;
    logic count_a, count_b, ext_clk, gate_a, gate_b, req_a, req_b, tk_al, tk_bl;
    logic [31:0] seed;
    int err_count;
    int num_checks;
    logic [7:0] addrs [8] = '{8'h89, 8'h8A, 8'h8B, 8'h8C, 8'h8D, 8'h8E, 8'h90, 8'h91};
    logic [7:0] masks [8] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h03, 8'h0F};
    logic [7:0] ticks [5] = '{8'h28, 8'h78, 8'h0A, 8'h02, 8'hC8};
    int waits [5] = '{478, 478, 478, 0, 198};

    dlct_pins_model u_pins (.sys_clk(sys_clk), .count_a(count_a), .count_b(count_b),
        .ext_clk(ext_clk), .gate_a(gate_a), .gate_b(gate_b));

    dlct_timers u_dut (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .timer_a_count_pin(count_a), .timer_b_count_pin(count_b), .ext_irq_pin_a(gate_a),
        .ext_irq_pin_b(gate_b), .ext_clock_pin(ext_clk), .timer_a_irq_enable(en_a),
        .timer_b_irq_enable(en_b), .timer_a_irq_ack(ack_a), .timer_b_irq_ack(ack_b),
        .timer_a_irq_req(req_a), .timer_b_irq_req(req_b), .timer_b_overflow_pulse(ovp),
        .aux_timer_a_low_tick(tk_al), .aux_timer_a_high_tick(tk_ah),
        .aux_timer_b_low_tick(tk_bl), .aux_timer_b_high_tick(tk_bh));

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    // Overflow pulses seen by the consumers of timer B
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            n_ovf <= 8'h00;
        end else if (ovp) begin
            n_ovf <= n_ovf + 8'h01;
        end
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        chk(d, exp);
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    initial begin
        #600000;
        err_count++;
        results();
    end

    initial begin
        {reset_n, reg_wr, reg_rd, ack_a, ack_b} = '0;
        {reg_addr, reg_wdata} = '0;
        {en_a, en_b} = 2'b11;
        {err_count, num_checks} = '0;
        seed = 32'h7D19;
        repeat (12) @(posedge sys_clk);
        reset_n <= 1'b1;
        rchk(8'h88, 8'h00);
        for (int i = 0; i < 8; i++) begin
            rchk(addrs[i], 8'h00);
            seed = lfsr(seed);
            wr(addrs[i], seed[7:0]);
            rchk(addrs[i], seed[7:0] & masks[i]);
        end
        wr(8'h8F, 8'h5A);
        rchk(8'h8F, 8'h00);
        $display("test registers done");
        wr(8'h8E, 8'h00);
        wr(8'h90, 8'h00);
        wr(8'h91, 8'h00);
        // Timer A counts pin edges in 16-bit mode across the all-ones boundary
        wr(8'h89, 8'h05);
        wr(8'h8A, 8'hFE);
        wr(8'h8C, 8'hFF);
        wr(8'h88, 8'h10);
        rchk(8'h8A, 8'hFE);
        u_pins.edges(0, 3, 2);
        repeat (8) @(posedge sys_clk);
        rchk(8'h8A, 8'h01);
        rchk(8'h8C, 8'h00);
        rchk(8'h88, 8'h30);
        chk({7'h00, req_a}, 8'h01);
        @(posedge sys_clk);
        ack_a <= 1'b1;
        @(posedge sys_clk);
        ack_a <= 1'b0;
        rchk(8'h88, 8'h10);
        // Thirteen-bit mode rolls over after the fifth low bit
        wr(8'h88, 8'h00);
        wr(8'h89, 8'h04);
        wr(8'h8C, 8'hFF);
        wr(8'h8A, 8'hFF);
        wr(8'h88, 8'h10);
        u_pins.edges(0, 1, 3);
        repeat (8) @(posedge sys_clk);
        rd(8'h8A, v0);
        chk(v0 & 8'h1F, 8'h00);
        rchk(8'h8C, 8'h00);
        rchk(8'h88, 8'h30);
        wr(8'h88, 8'h10);
        rchk(8'h88, 8'h10);
        $display("test count modes done");
        // Timer B gated by pin B active high, auto-reload
        wr(8'h88, 8'h00);
        wr(8'h89, 8'hE0);
        wr(8'h90, 8'h02);
        wr(8'h8D, 8'hF0);
        wr(8'h8B, 8'hFE);
        wr(8'h88, 8'h40);
        u_pins.edges(1, 2, 2);
        repeat (8) @(posedge sys_clk);
        rchk(8'h8B, 8'hFE);
        @(posedge sys_clk);
        u_pins.drive(4, 1'b1);
        u_pins.edges(1, 3, 3);
        repeat (8) @(posedge sys_clk);
        rchk(8'h8B, 8'hF1);
        rchk(8'h8D, 8'hF0);
        rchk(8'h88, 8'hC0);
        chk({7'h00, req_b}, 8'h01);
        chk(n_ovf, 8'h01);
        $display("test gate and reload done");
        // Time bases: three prescale codes, external clock, then system clock
        wr(8'h88, 8'h00);
        wr(8'h89, 8'h01);
        for (int c = 0; c < 5; c++) begin
            wr(8'h8E, (c == 4) ? 8'h04 : c[7:0]);
            wr(8'h88, 8'h10);
            rd(8'h8A, v0);
            if (c == 3) begin
                u_pins.edges(2, 16, 2);
                repeat (8) @(posedge sys_clk);
            end else begin
                repeat (waits[c]) @(posedge sys_clk);
            end
            rd(8'h8A, v1);
            chk(v1 - v0, ticks[c]);
            wr(8'h88, 8'h00);
        end
        for (int c = 0; c < 3; c++) begin
            wr(8'h91, (c == 2) ? 8'h0C : 8'h00);
            wr(8'h8E, (c == 1) ? 8'h50 : (c == 2) ? 8'hA0 : 8'h00);
            {ca, cb, ha, hb} = '0;
            repeat (24) begin
                @(posedge sys_clk);
                #1;
                ca = ca + {7'h00, tk_al};
                cb = cb + {7'h00, tk_bl};
                ha = ha + {7'h00, tk_ah};
                hb = hb + {7'h00, tk_bh};
            end
            chk(ca, (c == 1) ? 8'h18 : 8'h02);
            chk(cb, (c == 1) ? 8'h18 : 8'h02);
            chk(ha, (c == 0) ? 8'h02 : 8'h18);
            chk(hb, (c == 0) ? 8'h02 : 8'h18);
        end
        $display("test time bases done");
        // Split mode: B runs on its mode field, A high on B's run bit
        wr(8'h89, 8'h33);
        wr(8'h8D, 8'hFF);
        wr(8'h8B, 8'h1F);
        wr(8'h8C, 8'hF0);
        wr(8'h8A, 8'hF8);
        wr(8'h8E, 8'h0C);
        wr(8'h89, 8'h03);
        rd(8'h8B, v0);
        chk(v0, 8'h00);
        repeat (28) @(posedge sys_clk);
        rchk(8'h8B, 8'h1E);
        rchk(8'h8C, 8'hF0);
        rchk(8'h88, 8'h00);
        chk(n_ovf, 8'h02);
        wr(8'h88, 8'h50);
        repeat (20) @(posedge sys_clk);
        rchk(8'h88, 8'hF0);
        wr(8'h89, 8'h33);
        rd(8'h8B, v0);
        repeat (10) @(posedge sys_clk);
        rchk(8'h8B, v0);
        $display("test split mode done");
        results();
    end
endmodule
